/* File: include/etm_cfg.svh */
/*
 * Constants for the measurement-hold sequencer of a panel meter.
 * Assumes one 125 MHz clock; startup delay counts come from that rate.
 */
// How it works
// - Five trigger modes; continuous is the default after reset.
// - Continuous: measure always; timing only lights the trigger indicator.
// - Sample capture: one sample at timing assertion, shown until next.
// - Maximum track: keep largest while timing on, show it after release.
// - Minimum track: keep smallest while timing on, show it after release.
// - Span track: track both extremes, show maximum minus minimum.
// - Hold freezes display at its edge; timing, startup and zero ignored.
// - Continuous with scaling error: keep acquiring, flag error on display.
// - Hold taken during error and kept after it clears shows captured value.
// - Reset input clears data, stops measuring, reading shows no data.
// - Sample capture: timing assertions during reset capture nothing.
// - Sample capture: scaling error stops acquisition; timing edges ignored.
// - Analog output follows displayed reading; zero when no data exists.
// - Trigger inputs are active low; falling edge is assertion.
// - Startup input assertion suppresses measurement for the startup delay.
`ifndef ETM_CFG_SVH
`define ETM_CFG_SVH

// ***************************************************************
// Timing
// ***************************************************************
`define ETM_CLK_MHZ        125
`define ETM_STARTUP_MS     100
`define ETM_STARTUP_CYC    (`ETM_STARTUP_MS * `ETM_CLK_MHZ * 1000)

// ***************************************************************
// Widths and values
// ***************************************************************
`define ETM_CNT_W          32
`define ETM_ZERO_VAL       32'h0000_0000
`define ETM_CNT_ONE        32'h0000_0001

// ***************************************************************
// Trigger pin positions
// ***************************************************************
`define ETM_NUM_PINS       5
`define ETM_PIN_TIM        0
`define ETM_PIN_HLD        1
`define ETM_PIN_RST        2
`define ETM_PIN_ZRO        3
`define ETM_PIN_SUP        4

`endif

/* File: include/etm_pkg.sv */
/*
 * Types for the measurement-hold sequencer.
 * Assumes the constants header is included by design files.
 */
package etm_pkg;

  // ***************************************************************
  // Trigger modes
  // ***************************************************************
  typedef enum logic [2:0] {
    ETM_CONTINUOUS_MODE,
    ETM_SAMPLE_CAPTURE_MODE,
    ETM_MAXIMUM_TRACK_MODE,
    ETM_MINIMUM_TRACK_MODE,
    ETM_SPAN_TRACK_MODE
  } etm_mode_t;

endpackage

/* File: src/etm_event_trigger.sv */
/*
 * Measurement-hold sequencer: trigger input handling, extreme tracking,
 * display value and analog output code.
 * Assumes converter samples arrive with a same-clock valid strobe and the
 * trigger lines come straight from pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "etm_cfg.svh"

module etm_event_trigger #(
  parameter int          DW          = 20,
  parameter logic [31:0] STARTUP_CYC = `ETM_STARTUP_CYC
) (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  // Configuration
  input  wire etm_pkg::etm_mode_t MODE,
  // Trigger pins, active low
  input  wire logic              TIMING_N,
  input  wire logic              HOLD_N,
  input  wire logic              RESET_N,
  input  wire logic              ZERO_N,
  input  wire logic              STARTUP_DELAY_INPUT_N,
  // Converter side
  input  wire logic              SAMPLE_VALID,
  input  wire logic signed [DW-1:0] SAMPLE,
  input  wire logic              SCALE_ERR,
  // Outputs
  output logic signed [DW-1:0]   DISPLAY_VALUE,
  output logic                   DISPLAY_VALID,
  output logic                   DISPLAY_ERR,
  output logic                   TRIGGER_INDICATOR,
  output logic                   ZERO_REQ,
  output logic signed [DW-1:0]   ANALOG_OUT
);
  import etm_pkg::*;

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  // Index: 0 timing, 1 hold, 2 reset, 3 zero, 4 startup
  logic      [`ETM_NUM_PINS-1:0] pins;
  wire logic [`ETM_NUM_PINS-1:0] act;
  wire logic [`ETM_NUM_PINS-1:0] fall;
  wire logic [`ETM_NUM_PINS-1:0] rise;

  assign pins = {STARTUP_DELAY_INPUT_N, ZERO_N, RESET_N, HOLD_N, TIMING_N};

  // Flops live per pin so no two processes write one vector
  genvar gi;
  generate
    for (gi = 0; gi < `ETM_NUM_PINS; gi++) begin : g_sync
      logic meta_ff;
      logic sync_ff;
      logic prev_ff;
      always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          meta_ff <= 1'b1;
          sync_ff <= 1'b1;
          prev_ff <= 1'b1;
        end else begin
          meta_ff <= pins[gi];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end
      assign act[gi]  = ~sync_ff;
      assign fall[gi] = prev_ff & ~sync_ff;
      assign rise[gi] = ~prev_ff & sync_ff;
    end
  endgenerate

  logic timing_on;
  logic hold_on;
  logic reset_on;
  logic timing_fall;
  logic timing_rise;
  logic hold_fall;
  assign timing_on   = act[`ETM_PIN_TIM];
  assign hold_on     = act[`ETM_PIN_HLD];
  assign reset_on    = act[`ETM_PIN_RST];
  assign timing_fall = fall[`ETM_PIN_TIM];
  assign timing_rise = rise[`ETM_PIN_TIM];
  assign hold_fall   = fall[`ETM_PIN_HLD];

  // ***************************************************************
  // Startup delay
  // ***************************************************************
  // Hold blocks the startup input, so a start under hold is lost
  logic [`ETM_CNT_W-1:0] start_cnt_ff;
  logic                  start_busy;
  assign start_busy = (start_cnt_ff != `ETM_ZERO_VAL);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      start_cnt_ff <= `ETM_ZERO_VAL;
    end else if (fall[`ETM_PIN_SUP] && !hold_on) begin
      start_cnt_ff <= STARTUP_CYC;
    end else if (start_busy) begin
      start_cnt_ff <= start_cnt_ff - `ETM_CNT_ONE;
    end
  end

  // ***************************************************************
  // Measurement
  // ***************************************************************
  logic       meas_ok;
  logic       span_mode;
  logic       max_mode;
  logic       min_mode;
  logic signed [DW-1:0] max_ff;
  logic signed [DW-1:0] min_ff;
  logic signed [DW-1:0] live_ff;
  logic       have_ff;
  logic       ext_ff;

  assign meas_ok   = SAMPLE_VALID && !reset_on && !start_busy;
  assign max_mode  = (MODE == ETM_MAXIMUM_TRACK_MODE);
  assign min_mode  = (MODE == ETM_MINIMUM_TRACK_MODE);
  assign span_mode = (MODE == ETM_SPAN_TRACK_MODE);

  // Live or sampled value and the no-data flag
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      live_ff <= '0;
      have_ff <= 1'b0;
    end else if (reset_on) begin
      live_ff <= '0;
      have_ff <= 1'b0;
    end else if (hold_on) begin
      live_ff <= live_ff;
    end else begin
      case (MODE)
        ETM_SAMPLE_CAPTURE_MODE: begin
          if (timing_fall && meas_ok && !SCALE_ERR) begin
            live_ff <= SAMPLE;
            have_ff <= 1'b1;
          end
        end
        ETM_MAXIMUM_TRACK_MODE, ETM_MINIMUM_TRACK_MODE,
        ETM_SPAN_TRACK_MODE: begin
          if (timing_rise && ext_ff) begin
            have_ff <= 1'b1;
          end
        end
        // Unused codes behave as continuous, the fallback mode
        default: begin
          if (meas_ok) begin
            live_ff <= SAMPLE;
            have_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // Extreme tracking; a fresh timing assertion restarts the window
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      max_ff <= '0;
      min_ff <= '0;
      ext_ff <= 1'b0;
    end else if (reset_on) begin
      ext_ff <= 1'b0;
    end else if (!hold_on && (max_mode || min_mode || span_mode)) begin
      if (timing_fall) begin
        ext_ff <= 1'b0;
      end else if (timing_on && meas_ok && !SCALE_ERR) begin
        ext_ff <= 1'b1;
        if (!ext_ff || SAMPLE > max_ff) begin
          max_ff <= SAMPLE;
        end
        if (!ext_ff || SAMPLE < min_ff) begin
          min_ff <= SAMPLE;
        end
      end
    end
  end

  // ***************************************************************
  // Display and outputs
  // ***************************************************************
  logic signed [DW-1:0] shown;
  logic                 shown_ok;
  logic signed [DW-1:0] frz_ff;
  logic                 frz_ok_ff;
  logic                 shown_err;

  always_comb begin
    shown    = live_ff;
    shown_ok = have_ff;
    case (MODE)
      ETM_MAXIMUM_TRACK_MODE: shown = max_ff;
      ETM_MINIMUM_TRACK_MODE: shown = min_ff;
      ETM_SPAN_TRACK_MODE:    shown = DW'(max_ff - min_ff);
      default:                shown = live_ff;
    endcase
    if ((max_mode || min_mode || span_mode) && timing_on && !hold_on) begin
      shown_ok = 1'b0;
    end
  end

  // Frozen copy taken at the hold assertion, also during scaling error
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      frz_ff    <= '0;
      frz_ok_ff <= 1'b0;
    end else if (hold_fall) begin
      frz_ff    <= shown;
      frz_ok_ff <= shown_ok;
    end
  end

  assign shown_err = SCALE_ERR;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      DISPLAY_VALUE     <= '0;
      DISPLAY_VALID     <= 1'b0;
      DISPLAY_ERR       <= 1'b0;
      TRIGGER_INDICATOR <= 1'b0;
      ZERO_REQ          <= 1'b0;
      ANALOG_OUT        <= '0;
    end else begin
      DISPLAY_ERR       <= shown_err;
      TRIGGER_INDICATOR <= timing_on && !hold_on;
      ZERO_REQ          <= fall[`ETM_PIN_ZRO] && !hold_on;
      // On the hold edge the frozen copy is not loaded yet: show live
      if (hold_on && !reset_on && !hold_fall) begin
        DISPLAY_VALUE <= frz_ok_ff ? frz_ff : '0;
        DISPLAY_VALID <= frz_ok_ff;
        ANALOG_OUT    <= frz_ok_ff ? frz_ff : '0;
      end else begin
        DISPLAY_VALUE <= (shown_ok && !reset_on) ? shown : '0;
        DISPLAY_VALID <= shown_ok && !reset_on;
        ANALOG_OUT    <= (shown_ok && !reset_on) ? shown : '0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: bench/etm_event_trigger_properties.sv */
/*
 * Port checker for the measurement-hold sequencer.
 * Assumes one clock domain and DW equal to the bound instance.
 */
`timescale 1ns/1ps
`default_nettype none
`include "etm_cfg.svh"

module etm_event_trigger_properties
  import etm_pkg::*;
#(
  parameter int          DW          = 20,
  parameter logic [31:0] STARTUP_CYC = `ETM_STARTUP_CYC
) (
  // Clock and reset
  input wire logic                 MCLK,
  input wire logic                 RST_N,
  // Configuration and pins
  input wire etm_mode_t            MODE,
  input wire logic                 TIMING_N,
  input wire logic                 HOLD_N,
  input wire logic                 RESET_N,
  input wire logic                 ZERO_N,
  input wire logic                 STARTUP_DELAY_INPUT_N,
  // Converter side
  input wire logic                 SAMPLE_VALID,
  input wire logic signed [DW-1:0] SAMPLE,
  input wire logic                 SCALE_ERR,
  // Outputs watched
  input wire logic signed [DW-1:0] DISPLAY_VALUE,
  input wire logic                 DISPLAY_VALID,
  input wire logic                 DISPLAY_ERR,
  input wire logic                 TRIGGER_INDICATOR,
  input wire logic                 ZERO_REQ,
  input wire logic signed [DW-1:0] ANALOG_OUT
);
  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Cycles since the startup pin was last low; saturates, so a pin
  // never pulsed reads as long quiet
  logic [31:0] sup_quiet_ff;
  logic        sup_quiet;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sup_quiet_ff <= 32'hFFFF_FFFF;
    end else if (!STARTUP_DELAY_INPUT_N) begin
      sup_quiet_ff <= 32'h0000_0000;
    end else if (sup_quiet_ff != 32'hFFFF_FFFF) begin
      sup_quiet_ff <= sup_quiet_ff + 32'h0000_0001;
    end
  end

  // Margin covers the synchroniser and edge register
  assign sup_quiet = (sup_quiet_ff > STARTUP_CYC + 32'h0000_0004);

  // ***************************************************************
  // Properties
  // ***************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_analog_follow: assert property (
    ANALOG_OUT == (DISPLAY_VALID ? DISPLAY_VALUE : '0))
    else $error("analog output does not follow reading");
  a_nodata_zero: assert property (
    !DISPLAY_VALID |-> DISPLAY_VALUE == '0)
    else $error("reading not zero without data");
  a_reset_clears: assert property (
    (!RESET_N)[*6] |-> !DISPLAY_VALID)
    else $error("data kept under measurement reset");
  a_err_shown: assert property (
    SCALE_ERR && $past(RST_N) |=> DISPLAY_ERR)
    else $error("scaling error not indicated");
  a_trig_lit: assert property (
    (!TIMING_N && HOLD_N)[*5] |-> TRIGGER_INDICATOR)
    else $error("trigger indicator dark while timing on");
  a_zero_held: assert property (
    (!HOLD_N)[*7] |-> !ZERO_REQ)
    else $error("zero request while hold on");
  // Error cycles excluded, though the held value stays shown as an error sets or clears
  a_hold_freeze: assert property (
    (!HOLD_N && !SCALE_ERR)[*6] |=> $stable(DISPLAY_VALUE))
    else $error("reading moved under hold");
  a_cont_live: assert property (
    (HOLD_N && RESET_N && sup_quiet && !SCALE_ERR &&
     MODE == ETM_CONTINUOUS_MODE)[*8] ##0 SAMPLE_VALID
    ##1 !SCALE_ERR ##1 !SCALE_ERR
    |-> DISPLAY_VALID && DISPLAY_VALUE == $past(SAMPLE, 2))
    else $error("continuous reading not updated");

  c_zero: cover property (ZERO_REQ);
  c_err: cover property (DISPLAY_ERR);
  c_span: cover property (MODE == ETM_SPAN_TRACK_MODE && DISPLAY_VALID);
endmodule

bind etm_event_trigger etm_event_trigger_properties #(
  .DW(DW), .STARTUP_CYC(STARTUP_CYC)
) u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .MODE(MODE), .TIMING_N(TIMING_N),
  .HOLD_N(HOLD_N), .RESET_N(RESET_N), .ZERO_N(ZERO_N),
  .STARTUP_DELAY_INPUT_N(STARTUP_DELAY_INPUT_N),
  .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE(SAMPLE), .SCALE_ERR(SCALE_ERR),
  .DISPLAY_VALUE(DISPLAY_VALUE), .DISPLAY_VALID(DISPLAY_VALID),
  .DISPLAY_ERR(DISPLAY_ERR), .TRIGGER_INDICATOR(TRIGGER_INDICATOR),
  .ZERO_REQ(ZERO_REQ), .ANALOG_OUT(ANALOG_OUT)
);
`default_nettype wire

/* File: bench/etm_trig_ctl.sv */
/*
 * External controller model for the active-low trigger pins.
 * Assumes requests change just after a clock edge and last 2+ cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module etm_trig_ctl (
  // Requests: startup, zero, reset, hold, timing
  input  wire logic [4:0] req,
  // Pins, low means asserted
  output logic      [4:0] pins_n
);
  assign pins_n = ~req;
endmodule
`default_nettype wire

/* File: bench/test_event_trigger_measure_hold.sv */
/*
 * Self-checking bench for the measurement-hold sequencer.
 * Assumes the checker is bound and the pin model is compiled.
 */
`timescale 1ns/1ps
`default_nettype none

module test_event_trigger_measure_hold;
  import etm_pkg::*;
  localparam int DW = 20;
  localparam int TIM = 0, HLD = 1, RST = 2, ZRO = 3, SUP = 4;
  logic mclk = 1'b0, rst_n = 1'b0, sample_valid = 1'b0, scale_err = 1'b0;
  etm_mode_t mode = ETM_CONTINUOUS_MODE;
  logic signed [DW-1:0] sample = 20'sh0_0000, display_value, analog_out;
  logic display_valid, display_err, trigger_indicator, zero_req;
  logic [4:0] req = 5'h00;
  logic [4:0] pins_n;
  int errors = 0, checks_done = 0, zero_seen = 0;
  logic signed [DW-1:0] exp_trk [3] = '{20'sh0_000A, -20'sh0_0002,
                                        20'sh0_000C};

  etm_trig_ctl u_ctl (.req(req), .pins_n(pins_n));
  etm_event_trigger #(.DW(DW), .STARTUP_CYC(32'h0000_0010)) DUT (
    .MCLK(mclk), .RST_N(rst_n), .MODE(mode), .TIMING_N(pins_n[TIM]),
    .HOLD_N(pins_n[HLD]), .RESET_N(pins_n[RST]), .ZERO_N(pins_n[ZRO]),
    .STARTUP_DELAY_INPUT_N(pins_n[SUP]), .SAMPLE_VALID(sample_valid),
    .SAMPLE(sample), .SCALE_ERR(scale_err), .DISPLAY_VALUE(display_value),
    .DISPLAY_VALID(display_valid), .DISPLAY_ERR(display_err),
    .TRIGGER_INDICATOR(trigger_indicator), .ZERO_REQ(zero_req),
    .ANALOG_OUT(analog_out));

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic go(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic put(input logic signed [DW-1:0] v, input int n);
    @(posedge mclk);
    sample <= v;
    go(n);
  endtask
  // Pin changes need up to 4 cycles: sync, edge register and output register
  task automatic pin(input int b, input logic on, input int n);
    @(posedge mclk);
    req[b] <= on;
    go(n);
  endtask
  task automatic chk(input string nm, input logic [DW-1:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ***************************************************************
  // Clock, monitors and tests
  // ***************************************************************
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) if (zero_req === 1'b1) zero_seen++;
  // Tests need about 320 cycles; cut a hang at 12500
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial begin
    go(4);
    rst_n <= 1'b1;
    go(3);
    chk("analog", 20'h0_0000, analog_out);
    sample_valid <= 1'b1;
    put(20'sh0_0005, 6);
    chk("analog", 20'h0_0005, analog_out);
    pin(TIM, 1'b1, 6);
    chk("trig", 20'h0_0001, 20'(trigger_indicator));
    put(-20'sh0_0003, 6);
    chk("cont", -20'sh0_0003, display_value);
    pin(TIM, 1'b0, 2);
    scale_err <= 1'b1;
    put(20'sh0_0009, 6);
    chk("err", 20'h0_0001, 20'(display_err));
    pin(HLD, 1'b1, 6);
    scale_err <= 1'b0;
    put(20'sh0_0004, 6);
    chk("held", 20'sh0_0009, display_value);
    pin(ZRO, 1'b1, 6);
    pin(ZRO, 1'b0, 6);
    chk("zeros", 20'h0_0000, 20'(zero_seen));
    pin(HLD, 1'b0, 6);
    chk("live", 20'sh0_0004, display_value);
    pin(ZRO, 1'b1, 6);
    pin(ZRO, 1'b0, 6);
    chk("zeros", 20'h0_0001, 20'(zero_seen));
    pin(RST, 1'b1, 8);
    chk("valid", 20'h0_0000, 20'(display_valid));
    pin(RST, 1'b0, 6);
    mode <= ETM_SAMPLE_CAPTURE_MODE;
    put(20'sh0_0007, 2);
    pin(TIM, 1'b1, 6);
    put(20'sh0_0008, 6);
    chk("capture", 20'sh0_0007, display_value);
    pin(TIM, 1'b0, 6);
    pin(TIM, 1'b1, 6);
    chk("capture", 20'sh0_0008, display_value);
    pin(TIM, 1'b0, 4);
    scale_err <= 1'b1;
    put(20'sh0_0003, 2);
    pin(TIM, 1'b1, 6);
    scale_err <= 1'b0;
    go(4);
    chk("errcap", 20'sh0_0008, display_value);
    pin(TIM, 1'b0, 4);
    pin(RST, 1'b1, 4);
    pin(TIM, 1'b1, 6);
    pin(RST, 1'b0, 6);
    chk("rstcap", 20'h0_0000, 20'(display_valid));
    pin(TIM, 1'b0, 4);
    for (int m = 0; m < 3; m++) begin
      mode <= etm_mode_t'(m + 2);
      put(20'sh0_0006, 2);
      pin(TIM, 1'b1, 6);
      put(20'sh0_0004, 1);
      put(-20'sh0_0002, 1);
      put(20'sh0_000A, 1);
      put(20'sh0_0006, 6);
      pin(TIM, 1'b0, 6);
      chk("track", exp_trk[m], display_value);
    end
    mode <= ETM_CONTINUOUS_MODE;
    put(20'sh0_0001, 6);
    pin(SUP, 1'b1, 2);
    put(20'sh0_0015, 6);
    chk("startup", 20'sh0_0001, display_value);
    go(12);
    pin(SUP, 1'b0, 8);
    chk("startup", 20'sh0_0015, display_value);
    mode <= etm_mode_t'(3'h5);
    put(20'sh0_0002, 6);
    chk("default", 20'sh0_0002, display_value);
    report_and_stop;
  end
endmodule
`default_nettype wire
